// >>> idc_pkg.sv
// Constants and types shared by the image decode command front end.
package idc_pkg;
   // ********************************************
   // Header layout
   // ********************************************
   localparam int HDR_WORDS = 4;
   localparam logic [31:0] HDR_BYTES = 32'h0000_0010;
   localparam logic [31:0] MIN_LENGTH = 32'h0000_0011;
   localparam int COORD_W = 12;
   localparam int LO_WORD_LSB = 0;
   localparam int HI_WORD_LSB = 16;
   localparam int BASE_LSB = 7;
   localparam int BASE_W = 25;
   localparam int MODE_LSB = 14;
   localparam int SUB_LSB = 12;
   // ********************************************
   // Codes
   // ********************************************
   localparam logic [1:0] MODE_24BPP = 2'h2;
   localparam logic [1:0] MODE_16BPP = 2'h1;
   localparam logic [1:0] SUB_FIELD_420 = 2'h2;
   localparam logic [1:0] SUB_FIELD_422 = 2'h1;
   localparam logic [1:0] SUB_444 = 2'h0;
   localparam logic [1:0] SUB_422 = 2'h1;
   localparam logic [1:0] SUB_420 = 2'h2;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_LENGTH = 4'h1;
   localparam logic [3:0] ERR_SHORT = 4'h2;
   localparam logic [3:0] ERR_LONG = 4'h3;
   localparam logic [3:0] ERR_MODE = 4'h4;
   localparam logic [3:0] ERR_ZERO = 4'h5;
   localparam logic [3:0] ERR_BOUNDS = 4'h6;
   localparam logic [3:0] ERR_BIG = 4'h7;
   localparam logic [3:0] ERR_SMALL = 4'h8;
   localparam logic [3:0] ERR_PATH = 4'h9;
   // ********************************************
   // Bypass block layout in dwords
   // ********************************************
   localparam logic [6:0] LUMA_444_WORDS = 7'h10;
   localparam logic [6:0] LUMA_422_WORDS = 7'h20;
   localparam logic [6:0] LUMA_420_WORDS = 7'h40;
   localparam logic [6:0] CHROMA_WORDS = 7'h10;
   localparam logic [1:0] COMP_LUMA = 2'h0;
   localparam logic [1:0] COMP_CR = 2'h1;
   localparam logic [1:0] COMP_CB = 2'h2;
   // ********************************************
   // Reset values
   // ********************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      IDC_IDLE = 3'b000,
      IDC_HEADER = 3'b001,
      IDC_CHECK = 3'b010,
      IDC_FEED = 3'b011,
      IDC_DONE = 3'b100,
      IDC_ERROR = 3'b101
   } idc_state_e;
endpackage : idc_pkg

// >>> idc_front_end.sv
// FIFO and command front end of the image decode co-processor.
`timescale 1ns/10ps
`default_nettype none

module idc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_flush,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] count_reg;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data = mem_reg[rd_reg];
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
      end else if (i_flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge i_clock) begin
      if (push) mem_reg[wr_reg] <= i_in_data;
   end
endmodule : idc_fifo

// How it works
// - Decode command length is sixteen header bytes plus compressed image bytes.
// - Bypass command length is sixteen header bytes plus raw block bytes.
// - X, Y, width, height come from low twelve bits of header words.
// - Frame base is header dword bits 31:7, in 128-byte units.
// - Colour mode 10 is 24 bpp, 01 is 16 bpp, others reserved.
// - Sub-sampling field 10 is 4:2:0, 01 is 4:2:2, 00 is 4:4:4.
// - Image is baseline marker segments plus up to three padding bytes.
// - Bypass 4:4:4 block is 64 luma, 64 Cr, 64 Cb bytes.
// - Bypass 4:2:2 block is 128 luma, 64 Cr, 64 Cb bytes.
// - Bypass 4:2:0 block is 256 luma, 64 Cr, 64 Cb bytes.
// - Only whole blocks arrive; surplus pixels are clipped downstream.
// - Rectangle beyond frame resolution gives error 6.
// - Zero width or height gives error 5.
// - Unsupported colour mode gives error 4.
// - Length below seventeen bytes gives error 1.
// - Data exhausted before drawing ends gives error 2.
// - Data left or FIFO not empty at drawing end gives error 3.
// - Image too big gives error 7, too small gives error 8.
// - Any error aborts, reports to parser, then waits for deselect.
// - Deselect before completion abandons the command and returns to idle.
// - Fetch requests stop once the command length has been read.
// - Header is parsed and checked before any image data moves.
// - Bypass data is routed past the entropy decoder.
// - In 16 bpp pixels lose low 3, 2, 3 bits of red, green, blue.
module idc_front_end
   import idc_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // Command parser
   input wire logic i_select,
   input wire logic i_cmd_start,
   input wire logic i_cmd_bypass,
   input wire logic [31:0] i_cmd_length,
   output logic o_busy,
   output logic o_done,
   output logic o_error,
   output logic [3:0] o_error_code,
   // Fetch channel
   input wire logic i_fetch_valid,
   output logic o_fetch_ready,
   input wire logic [31:0] i_fetch_data,
   // Header parameters
   output logic o_hdr_valid,
   output logic [11:0] o_ul_x,
   output logic [11:0] o_ul_y,
   output logic [11:0] o_width,
   output logic [11:0] o_height,
   output logic [24:0] o_frame_base,
   output logic o_bpp24,
   output logic [11:0] o_hres,
   output logic [11:0] o_vres,
   output logic [1:0] o_subsamp,
   // Image data
   output logic o_img_valid,
   input wire logic i_img_ready,
   output logic [31:0] o_img_data,
   output logic o_img_bypass,
   output logic [1:0] o_img_comp,
   // Drawing status
   input wire logic i_draw_end,
   input wire logic i_img_big,
   input wire logic i_img_small,
   input wire logic i_path_error,
   // Pixel path
   input wire logic i_pix_valid,
   input wire logic [23:0] i_pix_rgb,
   output logic o_pix_valid,
   output logic [23:0] o_pix_data
);
   // ********************************************
   // Helpers
   // ********************************************
   function automatic logic [29:0] words_of(input logic [31:0] len);
      logic [32:0] sum;
      sum = {1'b0, len} + 33'd3;
      return sum[31:2];
   endfunction : words_of

   function automatic logic [23:0] pack565(input logic [23:0] rgb);
      return {8'h00, rgb[23:19], rgb[15:10], rgb[7:3]};
   endfunction : pack565

   idc_state_e state_reg, state_next;
   logic [29:0] fetch_left_reg;
   logic [29:0] feed_left_reg;
   logic [1:0] hdr_cnt_reg;
   logic [6:0] blk_cnt_reg;
   logic bypass_reg;
   logic [31:0] hdr_reg [HDR_WORDS];
   logic [3:0] code_reg, code_next;
   logic fifo_in_ready, fifo_valid;
   logic [31:0] fifo_data;

   // ********************************************
   // Header fields
   // ********************************************
   wire [1:0] mode_field = hdr_reg[3][LO_WORD_LSB+MODE_LSB +: 2];
   wire [1:0] sub_field = hdr_reg[3][HI_WORD_LSB+SUB_LSB +: 2];
   assign o_ul_x = hdr_reg[0][LO_WORD_LSB +: COORD_W];
   assign o_ul_y = hdr_reg[0][HI_WORD_LSB +: COORD_W];
   assign o_width = hdr_reg[1][LO_WORD_LSB +: COORD_W];
   assign o_height = hdr_reg[1][HI_WORD_LSB +: COORD_W];
   assign o_frame_base = hdr_reg[2][BASE_LSB +: BASE_W];
   assign o_hres = hdr_reg[3][LO_WORD_LSB +: COORD_W];
   assign o_vres = hdr_reg[3][HI_WORD_LSB +: COORD_W];
   assign o_bpp24 = (mode_field == MODE_24BPP);
   assign o_subsamp = (sub_field == SUB_FIELD_420) ? SUB_420 :
                      (sub_field == SUB_FIELD_422) ? SUB_422 : SUB_444;

   // ********************************************
   // Checks
   // ********************************************
   wire [12:0] x_end = {1'b0, o_ul_x} + {1'b0, o_width};
   wire [12:0] y_end = {1'b0, o_ul_y} + {1'b0, o_height};
   wire mode_bad = (mode_field != MODE_24BPP) && (mode_field != MODE_16BPP);
   wire size_bad = (o_width == '0) || (o_height == '0);
   wire bound_bad = (x_end > {1'b0, o_hres}) || (y_end > {1'b0, o_vres});
   wire len_bad = (i_cmd_length < MIN_LENGTH);
   wire [3:0] hdr_code = mode_bad ? ERR_MODE :
                         size_bad ? ERR_ZERO :
                         bound_bad ? ERR_BOUNDS : ERR_NONE;
   wire ran_out = (feed_left_reg == '0) && !fifo_valid && !i_draw_end;
   wire residue = (fetch_left_reg != '0) || fifo_valid;
   wire [3:0] feed_code = i_path_error ? ERR_PATH :
                          (i_draw_end && residue) ? ERR_LONG :
                          ran_out ? ERR_SHORT :
                          i_img_big ? ERR_BIG :
                          i_img_small ? ERR_SMALL : ERR_NONE;

   // ********************************************
   // Fetch side and FIFO
   // ********************************************
   wire fetching = (state_reg == IDC_HEADER) || (state_reg == IDC_CHECK) ||
                   (state_reg == IDC_FEED);
   assign o_fetch_ready = fetching && fifo_in_ready && (fetch_left_reg != '0);
   wire fetch_take = o_fetch_ready && i_fetch_valid;
   wire hdr_pop = (state_reg == IDC_HEADER) && fifo_valid;
   assign o_img_valid = (state_reg == IDC_FEED) && fifo_valid;
   wire feed_pop = o_img_valid && i_img_ready;
   wire flush = !fetching;
   assign o_img_data = fifo_data;
   assign o_img_bypass = bypass_reg;

   // Header words and image words share the one FIFO so ordering is preserved.
   idc_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_flush(flush),
      .i_in_valid(i_fetch_valid && fetching && (fetch_left_reg != '0)),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_fetch_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(hdr_pop || feed_pop),
      .o_out_data(fifo_data)
   );

   // ********************************************
   // Bypass block component tracking
   // ********************************************
   wire [6:0] luma_words = (o_subsamp == SUB_420) ? LUMA_420_WORDS :
                           (o_subsamp == SUB_422) ? LUMA_422_WORDS : LUMA_444_WORDS;
   wire [6:0] cb_start = luma_words + CHROMA_WORDS;
   wire [6:0] blk_last = cb_start + CHROMA_WORDS - 7'd1;
   assign o_img_comp = (blk_cnt_reg < luma_words) ? COMP_LUMA :
                       (blk_cnt_reg < cb_start) ? COMP_CR : COMP_CB;

   // ********************************************
   // Control
   // ********************************************
   always_comb begin
      state_next = state_reg;
      code_next = code_reg;
      case (state_reg)
         IDC_IDLE: begin
            if (i_select && i_cmd_start) begin
               if (len_bad) begin
                  state_next = IDC_ERROR;
                  code_next = ERR_LENGTH;
               end else begin
                  state_next = IDC_HEADER;
                  code_next = ERR_NONE;
               end
            end
         end
         IDC_HEADER: begin
            if (hdr_pop && (hdr_cnt_reg == 2'(HDR_WORDS-1))) state_next = IDC_CHECK;
         end
         IDC_CHECK: begin
            if (hdr_code != ERR_NONE) begin
               state_next = IDC_ERROR;
               code_next = hdr_code;
            end else begin
               state_next = IDC_FEED;
            end
         end
         IDC_FEED: begin
            if (feed_code != ERR_NONE) begin
               state_next = IDC_ERROR;
               code_next = feed_code;
            end else if (i_draw_end) begin
               state_next = IDC_DONE;
            end
         end
         IDC_DONE: state_next = IDC_DONE;
         IDC_ERROR: state_next = IDC_ERROR;
         default: state_next = IDC_IDLE;
      endcase
      if (!i_select) state_next = IDC_IDLE;
   end

   assign o_busy = (state_reg != IDC_IDLE);
   assign o_error_code = code_reg;
   assign o_hdr_valid = (state_reg == IDC_FEED) || (state_reg == IDC_DONE);

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= IDC_IDLE;
         code_reg <= ERR_NONE;
         o_done <= 1'b0;
         o_error <= 1'b0;
      end else begin
         state_reg <= state_next;
         code_reg <= code_next;
         o_done <= (state_next == IDC_DONE) && (state_reg != IDC_DONE);
         o_error <= (state_next == IDC_ERROR) && (state_reg != IDC_ERROR);
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         bypass_reg <= 1'b0;
         fetch_left_reg <= '0;
         feed_left_reg <= '0;
      end else if (state_reg == IDC_IDLE) begin
         bypass_reg <= i_cmd_bypass;
         fetch_left_reg <= words_of(i_cmd_length);
         feed_left_reg <= words_of(i_cmd_length - HDR_BYTES);
      end else begin
         if (fetch_take) fetch_left_reg <= fetch_left_reg - 30'd1;
         if (feed_pop) feed_left_reg <= feed_left_reg - 30'd1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         hdr_cnt_reg <= '0;
         blk_cnt_reg <= '0;
         for (int i = 0; i < HDR_WORDS; i++) hdr_reg[i] <= RST_WORD;
      end else if (state_reg == IDC_IDLE) begin
         hdr_cnt_reg <= '0;
         blk_cnt_reg <= '0;
      end else begin
         if (hdr_pop) begin
            hdr_reg[hdr_cnt_reg] <= fifo_data;
            hdr_cnt_reg <= hdr_cnt_reg + 2'd1;
         end
         if (feed_pop) blk_cnt_reg <= (blk_cnt_reg == blk_last) ? '0 : blk_cnt_reg + 7'd1;
      end
   end

   // ********************************************
   // Pixel down-conversion
   // ********************************************
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pix_valid <= 1'b0;
         o_pix_data <= '0;
      end else begin
         o_pix_valid <= i_pix_valid;
         o_pix_data <= o_bpp24 ? i_pix_rgb : pack565(i_pix_rgb);
      end
   end

   // ********************************************
   // Assertions
   // ********************************************
   sequence s_start_good;
      (state_reg == IDC_IDLE) && i_select && i_cmd_start && !len_bad;
   endsequence
   sequence s_start_short;
      (state_reg == IDC_IDLE) && i_select && i_cmd_start && len_bad;
   endsequence

   a_len_error_code: assert property (@(posedge i_clock) disable iff (!i_rstn)
      s_start_short |=> (state_reg == IDC_ERROR) && (code_reg == ERR_LENGTH)
      ##0 o_error)
      else $error("short length not reported as code 1");
   a_no_feed_early: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_HEADER) || (state_reg == IDC_CHECK) |-> !o_img_valid)
      else $error("image data moved before header checked");
   a_fetch_limit: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (fetch_left_reg == '0) |-> !o_fetch_ready)
      else $error("fetch request beyond command length");
   a_deselect_idle: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !i_select |=> (state_reg == IDC_IDLE) && !o_busy)
      else $error("deselect did not return to idle");
   a_error_holds: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_ERROR) && i_select |=> (state_reg == IDC_ERROR) && $stable(code_reg))
      else $error("error state left while still selected");
   a_check_priority: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_CHECK) && i_select && mode_bad |=> code_reg == ERR_MODE)
      else $error("colour mode error not given priority");
   a_zero_size: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_CHECK) && i_select && !mode_bad && size_bad
      |=> (code_reg == ERR_ZERO) && o_error)
      else $error("zero size not reported as code 5");
   a_bounds: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_CHECK) && i_select && !mode_bad && !size_bad && bound_bad
      |=> code_reg == ERR_BOUNDS)
      else $error("out of frame not reported as code 6");
   a_long_message: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (state_reg == IDC_FEED) && i_select && !i_path_error && i_draw_end && residue
      |=> code_reg == ERR_LONG)
      else $error("residual data not reported as code 3");
   a_header_walk: assert property (@(posedge i_clock) disable iff (!i_rstn)
      s_start_good |=> (state_reg == IDC_HEADER) && (hdr_cnt_reg == 2'd0))
      else $error("good start did not enter header read");
   a_pix_strip: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !o_bpp24 |=> o_pix_data[23:16] == 8'h00)
      else $error("16 bpp pixel not packed");
endmodule : idc_front_end

`default_nettype wire

// >>> idc_fetch_model.sv
// Behavioural fetch channel source that hands queued dwords to the front end.
`timescale 1ns/10ps
`default_nettype none
module idc_fetch_model (
   // Clock and flow control
   input wire logic i_clock,
   input wire logic i_stall,
   input wire logic i_ready,
   // Dword stream
   output logic o_valid,
   output logic [31:0] o_data
);
   logic [31:0] q[$];
   logic take;
   initial begin
      o_valid = 1'b0;
      o_data = 32'h0000_0000;
      take = 1'b0;
   end
   // ****
   // Stream
   // ****
   task push(input logic [31:0] w);
      q.push_back(w);
   endtask : push
   task flush();
      q.delete();
      o_valid = 1'b0;
   endtask : flush
   // Ready is read mid-cycle, where the combinational path has settled.
   always @(negedge i_clock) take = o_valid && i_ready;
   always @(posedge i_clock) begin
      if (take && q.size() > 0) void'(q.pop_front());
      if (take || !o_valid) begin
         if (q.size() > 0 && !i_stall) begin
            o_valid <= 1'b1;
            o_data <= q[0];
         end else begin
            // A released bus inverts every bit each cycle, so the old word returns on alternate cycles.
            o_valid <= 1'b0;
            o_data <= ~o_data;
         end
      end
   end
endmodule : idc_fetch_model
`default_nettype wire

// >>> image_decode_command_front_end_tb_top.sv
// Self-checking bench for the image decode command front end.
`timescale 1ns/10ps
`default_nettype none
module image_decode_command_front_end_tb_top;
   import idc_pkg::*;
   logic i_clock, i_rstn, i_select, i_cmd_start, i_cmd_bypass, fv, stall;
   logic [31:0] i_cmd_length, fd, o_img_data;
   logic o_busy, o_done, o_error, o_fetch_ready, o_hdr_valid, o_bpp24;
   logic [3:0] o_error_code;
   logic [11:0] o_ul_x, o_ul_y, o_width, o_height, o_hres, o_vres;
   logic [24:0] o_frame_base;
   logic [1:0] o_subsamp, o_img_comp;
   logic o_img_valid, i_img_ready, o_img_bypass, i_draw_end, i_img_big;
   logic i_img_small, i_path_error, i_pix_valid, o_pix_valid;
   logic [23:0] i_pix_rgb, o_pix_data;
   logic [31:0] seed = 32'h0000_c410;
   int n_mismatch = 0, n_checks = 0, n_fetch = 0, runs = 0;
   int kinds[7] = '{0, 2, 3, 7, 8, 9, 1};
   idc_front_end DUT (.i_clock, .i_rstn, .i_select, .i_cmd_start, .i_cmd_bypass,
      .i_cmd_length, .o_busy, .o_done, .o_error, .o_error_code, .i_fetch_valid(fv),
      .o_fetch_ready, .i_fetch_data(fd), .o_hdr_valid, .o_ul_x, .o_ul_y, .o_width,
      .o_height, .o_frame_base, .o_bpp24, .o_hres, .o_vres, .o_subsamp, .o_img_valid,
      .i_img_ready, .o_img_data, .o_img_bypass, .o_img_comp, .i_draw_end, .i_img_big,
      .i_img_small, .i_path_error, .i_pix_valid, .i_pix_rgb, .o_pix_valid, .o_pix_data);
   idc_fetch_model src (.i_clock, .i_stall(stall), .i_ready(o_fetch_ready), .o_valid(fv),
      .o_data(fd));
   always #20 i_clock = ~i_clock;
   always @(negedge i_clock) if (fv === 1'b1 && o_fetch_ready === 1'b1) n_fetch++;
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task chk(input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   // ****
   // One command: header, checks, feed, ending event, deselect
   // ****
   task automatic run_cmd(input logic bp, input int dfx, input int sub, input int kind,
      input int nimg);
      int x, y, w, h, len, ec, k, g, lw;
      logic [1:0] mode;
      logic [24:0] base;
      logic [31:0] r;
      logic [31:0] img[$];
      logic fire;
      runs++;
      n_fetch = 0;
      mode = dfx[1] ? {2{xs() % 2 == 1}} : (runs % 2 == 1 ? MODE_24BPP : MODE_16BPP);
      w = dfx[2] && xs() % 2 == 0 ? 0 : 1 + xs() % 64;
      h = dfx[2] && w != 0 ? 0 : 1 + xs() % 64;
      x = dfx[3] ? 2049 - w : 2048 - w - xs() % 2;
      y = 1024 - h - xs() % 2;
      base = 25'(xs());
      len = kind == 3 ? 20 + 4 * nimg : 16 + 4 * nimg - (kind == 0 ? xs() % 4 : 0);
      if (dfx[0]) len = xs() % 17;
      ec = len < 17 ? 1 : mode != MODE_24BPP && mode != MODE_16BPP ? 4 :
         w == 0 || h == 0 ? 5 : x + w > 2048 || y + h > 1024 ? 6 : 0;
      r = xs();
      src.push({r[3:0], 12'(y), r[7:4], 12'(x)});
      src.push({r[11:8], 12'(h), r[15:12], 12'(w)});
      src.push({base, r[22:16]});
      // Width 2048 keeps the 24 bpp resolution a multiple of eight.
      src.push({r[25:24], 2'(sub), 12'h400, mode, r[27:26], 12'h800});
      for (k = 0; k < nimg + 2; k++) begin
         img.push_back(xs());
         src.push(img[k]);
      end
      @(posedge i_clock);
      i_cmd_start <= 1'b1;
      i_cmd_bypass <= bp;
      i_cmd_length <= len;
      stall <= 1'b0;
      i_img_ready <= 1'b0;
      @(posedge i_clock);
      i_cmd_start <= 1'b0;
      @(negedge i_clock);
      for (g = 0; g < 40 && o_error !== 1'b1 && o_hdr_valid !== 1'b1; g++) @(negedge i_clock);
      if (ec != 0) begin
         chk(o_error, 1'b1);
         chk(o_error_code, ec);
      end else begin
         chk(o_hdr_valid, 1'b1);
         chk({o_ul_x, o_ul_y, o_width, o_height, o_hres, o_vres},
            {12'(x), 12'(y), 12'(w), 12'(h), 12'h800, 12'h400});
         chk({o_frame_base, o_bpp24, o_subsamp, o_img_bypass},
            {base, mode == MODE_24BPP, sub == 3 ? 2'h0 : 2'(sub), bp});
         r = xs();
         @(posedge i_clock);
         i_pix_valid <= 1'b1;
         i_pix_rgb <= r[23:0];
         @(posedge i_clock);
         i_pix_valid <= 1'b0;
         @(negedge i_clock);
         chk({o_pix_valid, o_pix_data}, {1'b1, mode == MODE_24BPP ? r[23:0] :
            {8'h00, r[23:19], r[15:10], r[7:3]}});
         repeat (4) @(negedge i_clock);
         chk({o_fetch_ready, o_img_valid}, 2'h1);
         k = 0;
         lw = sub == 2 ? 64 : sub == 1 ? 32 : 16;
         for (g = 0; g < 3000 && k < nimg; g++) begin
            @(negedge i_clock);
            if (o_error === 1'b1 || o_done === 1'b1) break;
            fire = 1'b0;
            if (o_img_valid === 1'b1 && i_img_ready === 1'b1) begin
               chk(o_img_data, img[k]);
               if (bp) chk(o_img_comp, k % (lw + 32) < lw ? 0 : k % (lw + 32) < lw + 16 ? 1 : 2);
               fire = k == (kind == 0 || kind == 3 ? nimg - 1 : 1);
               k++;
            end
            @(posedge i_clock);
            i_img_ready <= xs() % 4 != 0;
            stall <= xs() % 4 == 0;
            i_draw_end <= fire && (kind == 0 || kind == 3);
            i_img_big <= fire && kind == 7;
            i_img_small <= fire && kind == 8;
            i_path_error <= fire && kind == 9;
            i_select <= !(fire && kind == 1);
            if (fire && kind != 0 && kind != 3) break;
         end
         @(posedge i_clock);
         {i_draw_end, i_img_big, i_img_small, i_path_error} <= 4'h0;
         i_img_ready <= 1'b1;
         stall <= 1'b0;
         @(negedge i_clock);
         if (kind == 1) begin
            @(negedge i_clock);
            chk({o_busy, o_done, o_error}, 3'h0);
         end else begin
            for (g = 0; g < 20 && o_error !== 1'b1 && o_done !== 1'b1; g++) @(negedge i_clock);
            chk({o_done, o_error, o_error_code}, {kind == 0, kind != 0, 4'(kind)});
            if (kind == 0) chk(n_fetch, len / 4 + (len % 4 != 0));
         end
      end
      if (kind != 1 || ec != 0) begin
         @(negedge i_clock);
         chk(o_busy, 1'b1);
         @(posedge i_clock);
         i_select <= 1'b0;
         repeat (2) @(negedge i_clock);
         chk(o_busy, 1'b0);
      end
      src.flush();
      @(posedge i_clock);
      i_select <= 1'b1;
      $display("Test %0d done", runs);
   endtask : run_cmd
   // ****
   // Main sequence
   // ****
   initial begin
      i_clock = 1'b0;
      i_rstn = 1'b0;
      {i_select, i_cmd_start, i_cmd_bypass, stall, i_img_ready} = 5'h10;
      {i_draw_end, i_img_big, i_img_small, i_path_error, i_pix_valid} = 5'h00;
      i_cmd_length = 32'h0000_0000;
      i_pix_rgb = 24'h00_0000;
      @(negedge i_clock);
      chk({o_busy, o_done, o_error, o_error_code, o_fetch_ready, o_img_valid}, 9'h000);
      repeat (2) @(posedge i_clock);
      i_rstn <= 1'b1;
      for (int d = 0; d < 16; d++) run_cmd(1'b0, d, xs() % 4, 0, 6);
      for (int i = 0; i < 7; i++) run_cmd(xs() % 2 == 1, 0, xs() % 4, kinds[i], 6);
      for (int s = 0; s < 3; s++) run_cmd(1'b1, 0, s, 0, (s == 2 ? 64 : s == 1 ? 32 : 16) + 33);
      wrap_up();
   end
   // The whole run needs well under a tenth of this span; a hang ends here.
   initial begin
      #(40 * 60000);
      n_mismatch++;
      wrap_up();
   end
endmodule : image_decode_command_front_end_tb_top
`default_nettype wire
